//--- vih_cpu_model.sv
// cpu pipeline model: instruction completions, long calls and returns
`timescale 1ns/1ns
module vih_cpu_model (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic long_call_i,
    output logic      instr_done_o,
    output logic      return_from_irq_instr_done_o
);
    int gap;
    int depth;
    int cnt;
    // one instruction every three cycles, routine returns after four
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap <= 2;
            depth <= 0;
            cnt <= 0;
            instr_done_o <= 1'b0;
            return_from_irq_instr_done_o <= 1'b0;
        end else begin
            instr_done_o <= 1'b0;
            return_from_irq_instr_done_o <= 1'b0;
            if (long_call_i) begin // call takes five cycles
                depth <= depth + 1;
                cnt <= 0;
                gap <= 4;
            end else if (gap > 0) begin
                gap <= gap - 1;
            end else if (depth > 0 && cnt == 4) begin // routine ends by return
                gap <= 2;
                return_from_irq_instr_done_o <= 1'b1;
                depth <= depth - 1;
                cnt <= 0;
            end else begin
                gap <= 2;
                instr_done_o <= 1'b1;
                cnt <= cnt + 1;
            end
        end
    end
endmodule

//--- vih_ext_input.sv
// one external active-low request input with its pending flag
`timescale 1ns/1ns
module vih_ext_input (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic request_n_i,     // pin, asynchronous
    input  wire logic trigger_select_i, // 1 = falling edge, 0 = level
    input  wire logic sw_set_i,
    input  wire logic sw_clr_i,
    input  wire logic vector_ack_i,    // handler vectors to this source
    output logic      pending_o
);
    logic sync_a;
    logic sync_b;
    logic prev_level;

    // two flops before any logic looks at the pin
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= request_n_i;
            sync_b <= sync_a;
        end
    end

    // last settled level for falling edge detection
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prev_level <= 1'b1;
        end else begin
            prev_level <= sync_b;
        end
    end

    // pending flag: edge mode latches, level mode follows the pin
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pending_o <= 1'b0;
        end else if (!trigger_select_i) begin
            pending_o <= ~sync_b;
        end else if ((prev_level && !sync_b) || sw_set_i) begin
            pending_o <= 1'b1;                                     // set wins
        end else if (vector_ack_i || sw_clr_i) begin
            pending_o <= 1'b0;
        end
    end
endmodule

//--- vih_handler.sv
// vectored interrupt handler: flags, enables, arbitration, call and return
//
// Notes on behaviour
// - twenty-two sources, two priority levels
// - any flag of a source requests
// - flags set even when source disabled
// - call fixed vector after instruction ends
// - return resumes interrupted program flow
// - disabled pending source makes no request
// - global enable gates all sources
// - every source has own enable bit
// - only listed flags clear on vectoring
// - flag still set reenters after one instruction
// - software set flag acts like hardware; external inputs in level mode ignore software set and clear
// - external inputs active low, level or edge
// - edge flag cleared when vectoring
// - level flag follows input pin
// - fixed order, eight byte vector spacing
// - high preempts low, high never preempted
// - priority then order, sampled every clock
// - equal level waits return plus instruction
`timescale 1ns/1ns
module vih_handler
    import vih_pkg::*;
#(
    parameter int N_SRC = vih_pkg::NUM_SRC
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ext_request_in_a_i,
    input  wire logic              ext_request_in_b_i,
    input  wire logic              ext_trigger_select_a_i,
    input  wire logic              ext_trigger_select_b_i,
    input  wire logic [N_SRC-1:0]  src_event_i,
    input  wire logic [N_SRC-1:0]  periph_flags_i,
    input  wire logic [N_SRC-1:0]  sw_flag_set_i,
    input  wire logic [N_SRC-1:0]  sw_flag_clr_i,
    input  wire logic [7:0]        irq_enable_reg_i,
    input  wire logic [7:0]        ext_irq_enable_reg_1_i,
    input  wire logic [7:0]        ext_irq_enable_reg_2_i,
    input  wire logic [7:0]        irq_priority_reg_i,
    input  wire logic [7:0]        ext_irq_priority_reg_1_i,
    input  wire logic [7:0]        ext_irq_priority_reg_2_i,
    input  wire logic              cpu_instr_done_i,
    input  wire logic              cpu_return_from_irq_instr_done_i,
    output logic [N_SRC-1:0]       pending_o,
    output logic                   long_call_o,
    output logic [15:0]            call_vector_o,
    output logic [4:0]             call_source_o,
    output logic                   in_service_high_o,
    output logic                   in_service_low_o
);
    import vih_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VIH_RUN,
        VIH_AFTER_RETURN_FROM_IRQ_INSTR
    } vih_gate_e;

    vih_gate_e        gate;
    vih_gate_e        next_gate;
    logic [N_SRC-1:0] held_flags;
    logic [N_SRC-1:0] next_held_flags;
    logic             ext_a_pend;
    logic             ext_b_pend;
    logic [N_SRC-1:0] request;
    logic [N_SRC-1:0] enable_vec;
    logic [N_SRC-1:0] prio_vec;
    logic [N_SRC-1:0] elig_hi;
    logic [N_SRC-1:0] elig_lo;
    logic             win_valid;
    logic             win_high;
    logic [4:0]       win_idx;
    logic             next_win_valid;
    logic             next_win_high;
    logic [4:0]       next_win_idx;
    logic             still_ok;
    logic             take_call;
    logic [N_SRC-1:0] ack_vec;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // lowest set index wins
    function automatic logic [4:0] first_set(input logic [N_SRC-1:0] v);
        logic [4:0] idx;
        idx = IDX_RESET;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // vector address of a source index
    function automatic logic [15:0] vector_of(input logic [4:0] idx);
        return 16'(VEC_BASE + VEC_STEP * {11'h000, idx});
    endfunction

    // ------------------------------------------------------------
    // external inputs
    // ------------------------------------------------------------
    vih_ext_input u_ext_a (
        .clk_i            (clk_i),
        .reset_i          (reset_i),
        .request_n_i      (ext_request_in_a_i),
        .trigger_select_i (ext_trigger_select_a_i),
        .sw_set_i         (sw_flag_set_i[SRC_EXT_A]),
        .sw_clr_i         (sw_flag_clr_i[SRC_EXT_A]),
        .vector_ack_i     (ack_vec[SRC_EXT_A]),
        .pending_o        (ext_a_pend)
    );

    vih_ext_input u_ext_b (
        .clk_i            (clk_i),
        .reset_i          (reset_i),
        .request_n_i      (ext_request_in_b_i),
        .trigger_select_i (ext_trigger_select_b_i),
        .sw_set_i         (sw_flag_set_i[SRC_EXT_B]),
        .sw_clr_i         (sw_flag_clr_i[SRC_EXT_B]),
        .vector_ack_i     (ack_vec[SRC_EXT_B]),
        .pending_o        (ext_b_pend)
    );

    // ------------------------------------------------------------
    // pending flags held in the handler
    // ------------------------------------------------------------
    // one-hot acknowledge of the source being vectored
    always_comb begin
        ack_vec = '0;
        if (take_call) begin
            ack_vec[win_idx] = 1'b1;
        end
    end

    // set by event or software regardless of enable, set beats clear
    always_comb begin
        next_held_flags = held_flags;
        next_held_flags = next_held_flags & ~sw_flag_clr_i;
        next_held_flags = next_held_flags & ~(ack_vec & AUTO_CLR_MASK);
        next_held_flags = next_held_flags | src_event_i | sw_flag_set_i;
        next_held_flags[SRC_EXT_A] = 1'b0;
        next_held_flags[SRC_EXT_B] = 1'b0;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            held_flags <= PEND_RESET;
        end else begin
            held_flags <= next_held_flags;
        end
    end

    // visible pending state, including peripheral-owned flags
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pending_o <= PEND_RESET;
        end else begin
            pending_o <= request;
        end
    end

    // ------------------------------------------------------------
    // enables, priorities and arbitration
    // ------------------------------------------------------------
    // any flag of a source raises its request
    always_comb begin
        request = held_flags | periph_flags_i;
        request[SRC_EXT_A] = ext_a_pend | periph_flags_i[SRC_EXT_A];
        request[SRC_EXT_B] = ext_b_pend | periph_flags_i[SRC_EXT_B];
    end

    // per-source enable bits gated by the global enable
    always_comb begin
        enable_vec = {ext_irq_enable_reg_2_i, ext_irq_enable_reg_1_i,
                      irq_enable_reg_i[BASE_SRC_BITS-1:0]};
        prio_vec   = {ext_irq_priority_reg_2_i, ext_irq_priority_reg_1_i,
                      irq_priority_reg_i[BASE_SRC_BITS-1:0]};
        if (!irq_enable_reg_i[GLOBAL_EN_BIT]) begin
            enable_vec = '0;
        end
    end

    // high may preempt low; nothing preempts high; equal level waits
    always_comb begin
        elig_hi = (request & enable_vec & prio_vec)
                  & {N_SRC{!in_service_high_o}};
        elig_lo = (request & enable_vec & ~prio_vec)
                  & {N_SRC{!in_service_high_o && !in_service_low_o}};
        next_win_valid = (|elig_hi) || (|elig_lo);
        next_win_high  = |elig_hi;                                          // level first
        next_win_idx   = (|elig_hi) ? first_set(elig_hi) : first_set(elig_lo);
    end

    // decode sampled every clock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            win_valid <= 1'b0;
            win_high  <= 1'b0;
            win_idx   <= IDX_RESET;
        end else begin
            win_valid <= next_win_valid;
            win_high  <= next_win_high;
            win_idx   <= next_win_idx;
        end
    end

    // ------------------------------------------------------------
    // call and return sequencing
    // ------------------------------------------------------------
    // sampled winner must still fit the service state at call time
    always_comb begin
        still_ok  = win_high ? !in_service_high_o
                             : !(in_service_high_o || in_service_low_o);
        // winner was decoded a cycle ago: recheck flag and enables now
        still_ok  = still_ok && request[win_idx] && enable_vec[win_idx];
        take_call = cpu_instr_done_i && win_valid && still_ok
                    && (gate == VIH_RUN) && !long_call_o;
    end

    // after a return, one more instruction runs before any call
    always_comb begin
        next_gate = gate;
        unique case (gate)
            VIH_RUN: begin
                if (cpu_return_from_irq_instr_done_i) begin
                    next_gate = VIH_AFTER_RETURN_FROM_IRQ_INSTR;
                end
            end
            VIH_AFTER_RETURN_FROM_IRQ_INSTR: begin
                if (cpu_instr_done_i) begin
                    next_gate = VIH_RUN;
                end
            end
            default: begin
                next_gate = VIH_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate <= VIH_RUN;
        end else begin
            gate <= next_gate;
        end
    end

    // long call request to the winner's fixed vector
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            long_call_o   <= 1'b0;
            call_vector_o <= RESET_VECTOR;
            call_source_o <= IDX_RESET;
        end else begin
            long_call_o <= take_call;
            if (take_call) begin
                call_vector_o <= vector_of(win_idx);
                call_source_o <= win_idx;
            end
        end
    end

    // in-service levels: return retires the highest active level
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            in_service_high_o <= 1'b0;
            in_service_low_o  <= 1'b0;
        end else if (take_call) begin
            if (win_high) begin
                in_service_high_o <= 1'b1;
            end else begin
                in_service_low_o <= 1'b1;
            end
        end else if (cpu_return_from_irq_instr_done_i) begin
            if (in_service_high_o) begin
                in_service_high_o <= 1'b0;
            end else begin
                in_service_low_o <= 1'b0;
            end
        end
    end
endmodule

//--- vih_handler_chk.sv
// port assertions for the vectored interrupt handler
`timescale 1ns/1ns
module vih_handler_chk
    import vih_pkg::*;
#(
    parameter int N_SRC = vih_pkg::NUM_SRC
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [N_SRC-1:0] src_event_i,
    input  wire logic [N_SRC-1:0] sw_flag_set_i,
    input  wire logic [7:0]       irq_enable_reg_i,
    input  wire logic [7:0]       ext_irq_enable_reg_1_i,
    input  wire logic [7:0]       ext_irq_enable_reg_2_i,
    input  wire logic [7:0]       irq_priority_reg_i,
    input  wire logic [7:0]       ext_irq_priority_reg_1_i,
    input  wire logic [7:0]       ext_irq_priority_reg_2_i,
    input  wire logic             cpu_instr_done_i,
    input  wire logic             cpu_return_from_irq_instr_done_i,
    input  wire logic [N_SRC-1:0] pending_o,
    input  wire logic             long_call_o,
    input  wire logic [15:0]      call_vector_o,
    input  wire logic [4:0]       call_source_o,
    input  wire logic             in_service_high_o,
    input  wire logic             in_service_low_o
);
    import vih_pkg::*;
    // per-source enables, priorities and held-flag sets
    wire logic [21:0] en_all = {ext_irq_enable_reg_2_i, ext_irq_enable_reg_1_i, irq_enable_reg_i[5:0]};
    wire logic [21:0] pr_all = {ext_irq_priority_reg_2_i, ext_irq_priority_reg_1_i, irq_priority_reg_i[5:0]};
    wire logic [21:0] set_m  = (src_event_i | sw_flag_set_i) & 22'h3FFFFA;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------------------------------
    // call and return sequences
    // ----------------------------------------------------------------
    sequence s_call;
        long_call_o ##1 !long_call_o;
    endsequence
    sequence s_ret_step;
        cpu_return_from_irq_instr_done_i ##1 !cpu_instr_done_i [*2] ##1 cpu_instr_done_i;
    endsequence
    AST_VECTOR_MAP: assert property (long_call_o |-> call_vector_o == VEC_BASE + VEC_STEP * call_source_o)
        else $error("vector does not match source");
    AST_CALL_PULSE: assert property (long_call_o |-> s_call)
        else $error("call pulse too long");
    AST_CALL_ON_INSTR: assert property (long_call_o |-> $past(cpu_instr_done_i))
        else $error("call without finished instruction");
    AST_GLOBAL_GATE: assert property (long_call_o |-> $past(irq_enable_reg_i[7]))
        else $error("call while globally disabled");
    AST_SOURCE_ENABLED: assert property (long_call_o |-> (($past(en_all) >> call_source_o) & 22'h1) != 22'h0)
        else $error("call of disabled source");
    AST_LEVEL_MARK: assert property (long_call_o |-> (pr_all[call_source_o] ? in_service_high_o : in_service_low_o))
        else $error("wrong routine level marked");
    AST_HIGH_KEPT: assert property ($past(in_service_high_o) |-> !long_call_o)
        else $error("high routine preempted");
    AST_RET_STEP: assert property (s_ret_step |=> !long_call_o)
        else $error("call before one instruction after return");
    AST_RETURN: assert property (cpu_return_from_irq_instr_done_i && in_service_high_o |=> !in_service_high_o)
        else $error("return did not end high routine");
    AST_FLAG_SET: assert property (set_m != 22'h0 |-> ##2 (pending_o & $past(set_m, 2)) == $past(set_m, 2))
        else $error("set flag not pending");
endmodule
bind vih_handler vih_handler_chk #(.N_SRC(N_SRC)) u_chk (
    .clk_i                    (clk_i),
    .reset_i                  (reset_i),
    .src_event_i              (src_event_i),
    .sw_flag_set_i            (sw_flag_set_i),
    .irq_enable_reg_i         (irq_enable_reg_i),
    .ext_irq_enable_reg_1_i   (ext_irq_enable_reg_1_i),
    .ext_irq_enable_reg_2_i   (ext_irq_enable_reg_2_i),
    .irq_priority_reg_i       (irq_priority_reg_i),
    .ext_irq_priority_reg_1_i (ext_irq_priority_reg_1_i),
    .ext_irq_priority_reg_2_i (ext_irq_priority_reg_2_i),
    .cpu_instr_done_i         (cpu_instr_done_i),
    .cpu_return_from_irq_instr_done_i          (cpu_return_from_irq_instr_done_i),
    .pending_o                (pending_o),
    .long_call_o              (long_call_o),
    .call_vector_o            (call_vector_o),
    .call_source_o            (call_source_o),
    .in_service_high_o        (in_service_high_o),
    .in_service_low_o         (in_service_low_o)
);

//--- vih_handler_tb_top.sv
// self-checking bench for the vectored interrupt handler
`timescale 1ns/1ns
module vih_handler_tb_top;
    import vih_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, ext_a = 1'b1, ext_b = 1'b1, trig_a = 1'b0, glob = 1'b0;
    logic        trig_b = 1'b0;
    logic [21:0] ev = 22'h0, per = 22'h0, sws = 22'h0, swc = 22'h0, en_v = 22'h0, pr_v = 22'h0;
    logic        instr_done, return_from_irq_instr_done, long_call, ish, isl;
    logic [21:0] pend;
    logic [15:0] cvec;
    logic [4:0]  csrc;
    int          bad_count = 0, n_tests = 0, e, exp_q[$];
    vih_handler #(.N_SRC(NUM_SRC)) dut (.clk_i(clk_i), .reset_i(reset_i), .ext_request_in_a_i(ext_a),
        .ext_request_in_b_i(ext_b), .ext_trigger_select_a_i(trig_a), .ext_trigger_select_b_i(trig_b),
        .src_event_i(ev), .periph_flags_i(per), .sw_flag_set_i(sws), .sw_flag_clr_i(swc),
        .irq_enable_reg_i({glob, 1'b0, en_v[5:0]}), .ext_irq_enable_reg_1_i(en_v[13:6]),
        .ext_irq_enable_reg_2_i(en_v[21:14]), .irq_priority_reg_i({2'h0, pr_v[5:0]}),
        .ext_irq_priority_reg_1_i(pr_v[13:6]), .ext_irq_priority_reg_2_i(pr_v[21:14]),
        .cpu_instr_done_i(instr_done), .cpu_return_from_irq_instr_done_i(return_from_irq_instr_done), .pending_o(pend), .long_call_o(long_call),
        .call_vector_o(cvec), .call_source_o(csrc), .in_service_high_o(ish), .in_service_low_o(isl));
    vih_cpu_model cpu (.clk_i(clk_i), .reset_i(reset_i), .long_call_i(long_call),
        .instr_done_o(instr_done), .return_from_irq_instr_done_o(return_from_irq_instr_done));
    task automatic check(input logic c, input string m);
        n_tests++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // raise flags: 0 event pulse, 1 software set, 2 peripheral level
    task automatic raise(input logic [21:0] m, input int mode);
        @(posedge clk_i);
        ev <= (mode == 0) ? m : 22'h0;
        sws <= (mode == 1) ? m : 22'h0;
        per <= (mode == 2) ? (per | m) : per;
        @(posedge clk_i);
        ev <= 22'h0;
        sws <= 22'h0;
    endtask
    task automatic lower(input int s);
        @(posedge clk_i);
        swc <= 22'h1 << s;
        per[s] <= 1'b0;
        @(posedge clk_i);
        swc <= 22'h0;
    endtask
    task automatic wait_left(input int k);
        int t;
        t = 0;
        while (exp_q.size() > k && t < 400) begin
            @(posedge clk_i);
            t++;
        end
        check(exp_q.size() <= k, "expected call missing");
    endtask
    // reference queue: each call must be the oldest expected source
    always @(negedge clk_i) begin
        if (long_call === 1'b1) begin
            check(exp_q.size() != 0, "unexpected call");
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 31;
            check(csrc === 5'(e) && cvec === VEC_BASE + VEC_STEP * 16'(e), "wrong source or vector");
        end
    end
    initial forever #2 clk_i = ~clk_i;
    initial begin
        #60000;
        check(1'b0, "watchdog expired");
        print_verdict();
    end
    initial begin
        int s;
        logic au;
        s = $urandom(28642);
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        glob <= 1'b1;
        // every held or peripheral source alone, random priority and flag origin
        for (s = 1; s < 22; s++) begin
            if (s != 2) begin
                au = (s == 1 || s == 3 || s == 19);
                en_v <= 22'h1 << s;
                pr_v <= 22'($urandom);
                exp_q.push_back(s);
                raise(22'h1 << s, $urandom % (au ? 2 : 3));
                wait_left(0);
                repeat (2) @(posedge clk_i);
                check(pend[s] === ~au, "flag state after call");
                lower(s);
                repeat (24) @(posedge clk_i);
            end
        end
        // blocked by global enable, then by source enable
        glob <= 1'b0;
        pr_v <= 22'h0;
        en_v <= 22'h100;
        raise(22'h100, 0);
        repeat (30) @(posedge clk_i);
        check(pend[8] === 1'b1, "flag lost while disabled");
        glob <= 1'b1;
        en_v <= 22'h0;
        repeat (30) @(posedge clk_i);
        exp_q.push_back(8);
        en_v <= 22'h100;
        wait_left(0);
        lower(8);
        // flag left set across return re-enters
        en_v <= 22'h40;
        exp_q = {6, 6};
        raise(22'h40, 0);
        wait_left(0);
        lower(6);
        repeat (24) @(posedge clk_i);
        // high preempts low, equal level waits for return
        en_v <= 22'h230;
        pr_v <= 22'h200;
        exp_q = {4, 9, 5};
        raise(22'h10, 0);
        wait_left(2);
        lower(4);
        raise(22'h220, 0);
        wait_left(1);
        check(ish === 1'b1 && isl === 1'b1, "no nested high routine");
        lower(9);
        wait_left(0);
        lower(5);
        repeat (24) @(posedge clk_i);
        // same level, simultaneous: lower order number first
        en_v <= 22'h3000;
        pr_v <= 22'h0;
        exp_q = {12, 13};
        raise(22'h3000, 0);
        wait_left(1);
        lower(12);
        wait_left(0);
        lower(13);
        repeat (24) @(posedge clk_i);
        // input A on falling edge, input B on level
        trig_a <= 1'b1;
        en_v <= 22'h1;
        repeat (4) @(posedge clk_i);
        exp_q.push_back(0);
        ext_a <= 1'b0;
        wait_left(0);
        repeat (3) @(posedge clk_i);
        check(pend[0] === 1'b0, "edge flag kept");
        ext_a <= 1'b1;
        glob <= 1'b0;
        en_v <= 22'h4;
        ext_b <= 1'b0;
        repeat (30) @(posedge clk_i);
        check(pend[2] === 1'b1, "level flag not set");
        ext_b <= 1'b1;
        repeat (6) @(posedge clk_i);
        check(pend[2] === 1'b0, "level flag not cleared");
        exp_q.push_back(2);
        ext_b <= 1'b0;
        glob <= 1'b1;
        wait_left(0);
        ext_b <= 1'b1;
        repeat (30) @(posedge clk_i);
        // input B on falling edge
        trig_b <= 1'b1;
        repeat (4) @(posedge clk_i);
        exp_q.push_back(2);
        ext_b <= 1'b0;
        wait_left(0);
        repeat (3) @(posedge clk_i);
        check(pend[2] === 1'b0, "edge flag B kept");
        ext_b <= 1'b1;
        repeat (30) @(posedge clk_i);
        check(exp_q.size() == 0, "calls left over");
        print_verdict();
    end
endmodule

//--- vih_pkg.sv
// constants shared by the vectored interrupt handler
package vih_pkg;
    // ------------------------------------------------------------
    // sources and vectors
    // ------------------------------------------------------------
    localparam int          NUM_SRC       = 22;
    localparam int          IDX_W         = 5;
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam logic [15:0] VEC_STEP      = 16'h0008;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    // ------------------------------------------------------------
    // source positions
    // ------------------------------------------------------------
    localparam int          SRC_EXT_A     = 0;
    localparam int          SRC_TIMER0    = 1;
    localparam int          SRC_EXT_B     = 2;
    localparam int          SRC_TIMER1    = 3;
    localparam int          SRC_CAN       = 19;
    localparam int          BASE_SRC_BITS = 6;
    localparam int          GLOBAL_EN_BIT = 7;
    // flags cleared by hardware on vectoring (external ones handled per input)
    localparam logic [21:0] AUTO_CLR_MASK = 22'h08000A;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [21:0] PEND_RESET    = 22'h000000;
    localparam logic [4:0]  IDX_RESET     = 5'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          MIN_RESP_CYC  = 5;
    localparam int          SYNC_STAGES   = 2;
endpackage
